// File: dv/xbpi_mem.sv
`timescale 1ns/10ps
module xbpi_mem (
  input  logic        i_clk,
  input  logic        i_slow,
  input  logic [15:0] i_addr,
  input  logic [3:0]  i_ct,
  input  logic [3:0]  i_cs,
  input  logic [15:0] i_dl,
  output logic [15:0] o_dl = 16'h0000,
  output logic        o_wait_n = 1'b1
);
  logic [15:0] mem [16];
  logic [3:0]  cnt = 4'h0;
  // Slow mode asks for wait before the cycle, so early sampling sees it
  always @(posedge i_clk)
  begin
    cnt <= (&i_cs) ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    o_wait_n <= !(i_slow && cnt < 4'h6);
    if (!i_ct[0])
      mem[i_addr[3:0]][7:0] <= i_dl[7:0];
    if (!i_ct[1])
      mem[i_addr[3:0]][15:8] <= i_dl[15:8];
    // Released bus toggles so a stale value cannot pass
    o_dl <= !i_ct[2] ? mem[i_addr[3:0]] : ~o_dl;
  end
endmodule

// File: dv/xbpi_props.sv
`timescale 1ns/10ps
module xbpi_props #(
  parameter CLK_HALF = 2
) (
  input logic        i_clk,
  input logic        i_srst,
  input logic        i_req,
  input logic        i_req_read,
  input logic [23:0] i_req_addr,
  input logic [15:0] i_req_wdata,
  input logic [1:0]  i_req_be,
  input logic [1:0]  i_req_block,
  input logic        i_sep_mode,
  input logic        o_bus_held,
  input logic [3:0]  i_cm_in,
  input logic [3:0]  o_cm_out,
  input logic [3:0]  o_cm_oe,
  input logic [3:0]  i_bus_control_port_function_enable,
  input logic [3:0]  o_cs_out,
  input logic [3:0]  o_cs_oe,
  input logic [3:0]  o_ct_out,
  input logic [3:0]  o_ct_oe,
  input logic [7:0]  o_dh_out,
  input logic [7:0]  o_dh_oe,
  input logic [15:0] o_dl_out,
  input logic [15:0] o_dl_oe
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // Driven low write strobes and selects
  wire [1:0] wr_act = ~o_ct_out[1:0] & o_ct_oe[1:0];
  wire [3:0] cs_act = ~o_cs_out & o_cs_oe;

  a_clk_runs: assert property (i_bus_control_port_function_enable[1] [*8] |->
    o_cm_oe[1] && o_cm_out[1] != $past(o_cm_out[1], CLK_HALF)) else $error("clock pin stuck");
  a_rd_cause: assert property (!o_ct_out[2] && o_ct_oe[2] |-> i_req_read)
    else $error("read strobe in write");
  a_wr_cause: assert property (|wr_act |-> !i_req_read && (wr_act & ~i_req_be) == 2'b00)
    else $error("write strobe wrong lane");
  a_wr_data: assert property (|wr_act |-> o_dl_oe == 16'hffff && o_dl_out == i_req_wdata)
    else $error("write data not on bus");
  a_cs_block: assert property (cs_act != 4'h0 |-> cs_act == (4'h1 << i_req_block))
    else $error("wrong block select");
  a_idle_quiet: assert property (!i_req [*3] |-> (cs_act == 4'h0) && !(!o_ct_out[2] && o_ct_oe[2]))
    else $error("select or read active in idle");
  a_high_addr: assert property (cs_act != 4'h0 |-> o_dh_oe == 8'hff && o_dh_out == i_req_addr[23:16])
    else $error("high address wrong");
  a_mux_addr: assert property ($fell(o_ct_out[3]) && !i_sep_mode |->
    o_dl_oe == 16'hffff && o_dl_out == i_req_addr[15:0]) else $error("muxed address wrong");
  a_hold_float: assert property (o_bus_held |-> {o_dl_oe, o_ct_oe, o_cs_oe, o_dh_oe} == 32'h0000_0000)
    else $error("bus driven in hold");
  a_hold_grant: assert property ($fell(i_cm_in[2]) && !i_req |-> ##[1:40] o_bus_held)
    else $error("hold not granted");
endmodule

bind xbpi_top xbpi_props #(.CLK_HALF(CLK_HALF)) u_props (.*);

// File: dv/xbpi_top_tb.sv
`timescale 1ns/10ps
module xbpi_top_tb;
  logic        i_clk, i_srst, i_req, i_req_read, i_sep_mode, o_done, o_bus_held;
  logic [23:0] i_req_addr;
  logic [15:0] i_req_wdata, o_rdata, i_p9_in, o_p9_out, o_p9_oe, o_p9_pin_sync;
  logic [15:0] i_port9_function_enable, i_port9_function_select, i_port9_direction;
  logic [15:0] i_p9_port_data, i_p9_alt2_out, i_p9_alt2_oe, i_p9_open_drain;
  logic [15:0] i_dl_in, o_dl_out, o_dl_oe, i_data_port_function_enable, i_dl_direction;
  logic [15:0] i_dl_port_data;
  logic [7:0]  o_dh_out, o_dh_oe, i_upper_address_port_function_enable, i_dh_direction;
  logic [7:0]  i_dh_port_data;
  logic [3:0]  i_cm_in, o_cm_out, o_cm_oe, i_bus_control_port_function_enable, i_cm_direction;
  logic [3:0]  i_cm_port_data, o_cs_out, o_cs_oe, i_select_port_function_enable, i_cs_direction;
  logic [3:0]  i_cs_port_data, o_ct_out, o_ct_oe, i_strobe_port_function_enable, i_ct_direction;
  logic [3:0]  i_ct_port_data;
  logic [1:0]  i_req_be, i_req_block;
  logic        hreq_n, wait_n, slow;
  int          num_errors, compares, n, k;
  int          cyc[4];

  // Port-9 pins loop back; unused control inputs idle high
  assign i_p9_in = o_p9_out;
  assign i_cm_in = {1'b1, hreq_n, 1'b1, wait_n};

  // Read data needs the registered partner plus two sync flops before the late fall
  xbpi_top #(.CLK_HALF(2)) dut (.*);
  xbpi_mem u_mem (.i_clk, .i_slow(slow), .i_addr(o_p9_out), .i_ct(o_ct_out),
    .i_cs(o_cs_out), .i_dl(o_dl_out), .o_dl(i_dl_in), .o_wait_n(wait_n));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task print_verdict;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One bus cycle; request held until done, cycles left in n
  task op(input logic rd, input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    n = 0;
    i_req_read = rd;
    i_req_addr = {16'h1234, a};
    i_req_wdata = d;
    i_req_be = be;
    i_req = 1'b1;
    while (o_done !== 1'b1 && n < 300)
    begin
      @(negedge i_clk);
      n++;
    end
    i_req = 1'b0;
    if (n >= 300)
    begin
      num_errors++;
      $display("[ERR] op_done expected 1 seen %b", o_done);
      print_verdict;
    end
    else
      repeat (3) @(negedge i_clk);
  endtask

  initial
  begin
    {i_srst, hreq_n, slow, i_req, i_req_read, i_sep_mode} = 6'b110000;
    {i_req_addr, i_req_wdata, i_req_be, i_req_block, i_p9_alt2_oe, i_p9_open_drain} = '0;
    {i_port9_function_enable, i_port9_function_select, i_p9_port_data, i_p9_alt2_out} = '0;
    {i_dl_port_data, i_dh_port_data, i_cm_port_data, i_cs_port_data, i_ct_port_data} = '0;
    {i_data_port_function_enable, i_upper_address_port_function_enable} = '0;
    {i_bus_control_port_function_enable, i_select_port_function_enable} = '0;
    i_strobe_port_function_enable = 4'h0;
    {i_port9_direction, i_dl_direction, i_dh_direction, i_cm_direction} = '1;
    {i_cs_direction, i_ct_direction} = '1;
    repeat (2) @(negedge i_clk);
    chk("cm_oe_rst", 4'h0, o_cm_oe);
    i_srst = 1'b0;
    repeat (6) @(negedge i_clk);
    chk("clk_quiet", 2'b00, {o_cm_oe[1], o_cm_out[1]});
    // Bus pins to function use; low address moves as one group
    {i_data_port_function_enable, i_upper_address_port_function_enable} = '1;
    {i_bus_control_port_function_enable, i_select_port_function_enable} = '1;
    i_strobe_port_function_enable = 4'hf;
    i_port9_function_enable = 16'hffff;
    repeat (4) @(negedge i_clk);
    chk("clk_on", 1'b1, o_cm_oe[1]);
    chk("cm_oe_fn", 4'ha, o_cm_oe);
    // Every block, both bus modes, with and without wait
    for (k = 0; k < 4; k++)
    begin
      {slow, i_sep_mode} = k[1:0];
      i_req_block = k[1:0];
      op(1'b0, k[7:0], 16'ha5a0 | k[15:0], 2'b11);
      op(1'b1, k[7:0], 16'h0000, 2'b11);
      cyc[k] = n;
      chk("rdata", 16'ha5a0 | k[15:0], o_rdata);
    end
    chk("low_addr", 16'h3403, o_p9_out);
    chk("high_addr", 8'h12, o_dh_out);
    chk("wait_mux", 1'b1, cyc[2] > cyc[0]);
    chk("wait_sep", 1'b1, cyc[3] > cyc[1]);
    {slow, i_sep_mode} = 2'b00;
    op(1'b0, 8'h00, 16'h0077, 2'b01);
    op(1'b0, 8'h00, 16'h3300, 2'b10);
    op(1'b1, 8'h00, 16'h0000, 2'b11);
    chk("byte_lanes", 16'h3377, o_rdata);
    hreq_n = 1'b0;
    n = 0;
    while (o_bus_held !== 1'b1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    chk("hold_grant", 1'b1, o_bus_held);
    chk("hold_float", 24'h00_0000, {o_dl_oe, o_ct_oe, o_cs_oe});
    chk("grant_pin", 2'b10, {o_cm_oe[3], o_cm_out[3]});
    // Request made in hold must wait for the release
    fork
      op(1'b1, 8'h01, 16'h0000, 2'b11);
      begin
        repeat (30) @(negedge i_clk);
        hreq_n = 1'b1;
      end
    join
    chk("held_wait", 1'b1, n > 30);
    chk("held_rdata", 16'ha5a1, o_rdata);
    chk("grant_off", 2'b11, {o_cm_oe[3], o_cm_out[3]});
    i_port9_function_enable = 16'h0000;
    i_port9_direction = 16'h00ff;
    i_p9_port_data = 16'h5a5a;
    repeat (3) @(negedge i_clk);
    chk("p9_oe", 16'hff00, o_p9_oe);
    chk("p9_out", 16'h5a5a, o_p9_out);
    chk("p9_sync", 16'h5a5a, o_p9_pin_sync);
    i_port9_direction = 16'h0000;
    {i_p9_port_data, i_p9_open_drain} = '1;
    repeat (3) @(negedge i_clk);
    chk("p9_od", 16'he4ff, o_p9_oe);
    i_p9_open_drain = 16'h0000;
    {i_port9_function_enable, i_p9_alt2_oe} = '1;
    i_port9_function_select = 16'h00ff;
    i_p9_alt2_out = 16'hc3c3;
    repeat (3) @(negedge i_clk);
    chk("p9_sets", 16'h34c3, o_p9_out);
    print_verdict;
  end
endmodule

// File: logic/xbpi_regs.vh
`ifndef XBPI_REGS_VH
`define XBPI_REGS_VH

// Bus-control port pin positions
`define XBPI_CM_WAIT   0
`define XBPI_CM_CLK    1
`define XBPI_CM_HREQ   2
`define XBPI_CM_HACK   3
// Strobe port pin positions
`define XBPI_CT_WR0    0
`define XBPI_CT_WR1    1
`define XBPI_CT_RD     2
`define XBPI_CT_ADDRESS_LATCH_STROBE   3
// Port-9 bits with an open-drain option
`define XBPI_P9_OD_MASK 16'h1b00
// Default half period of the clock pin in system cycles
`define XBPI_CLK_HALF  2
`endif

// File: logic/xbpi_top.v
`timescale 1ns/10ps
`include "xbpi_regs.vh"

module xbpi_top #(
  parameter CLK_HALF = `XBPI_CLK_HALF
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_req,
  input  wire        i_req_read,
  input  wire [23:0] i_req_addr,
  input  wire [15:0] i_req_wdata,
  input  wire [1:0]  i_req_be,
  input  wire [1:0]  i_req_block,
  input  wire        i_sep_mode,
  output reg         o_done,
  output reg  [15:0] o_rdata,
  output reg         o_bus_held,
  input  wire [15:0] i_p9_in,
  output reg  [15:0] o_p9_out,
  output reg  [15:0] o_p9_oe,
  output reg  [15:0] o_p9_pin_sync,
  input  wire [15:0] i_port9_function_enable,
  input  wire [15:0] i_port9_function_select,
  input  wire [15:0] i_port9_direction,
  input  wire [15:0] i_p9_port_data,
  input  wire [15:0] i_p9_alt2_out,
  input  wire [15:0] i_p9_alt2_oe,
  input  wire [15:0] i_p9_open_drain,
  input  wire [3:0]  i_cm_in,
  output reg  [3:0]  o_cm_out,
  output reg  [3:0]  o_cm_oe,
  input  wire [3:0]  i_bus_control_port_function_enable,
  input  wire [3:0]  i_cm_direction,
  input  wire [3:0]  i_cm_port_data,
  output reg  [3:0]  o_cs_out,
  output reg  [3:0]  o_cs_oe,
  input  wire [3:0]  i_select_port_function_enable,
  input  wire [3:0]  i_cs_direction,
  input  wire [3:0]  i_cs_port_data,
  output reg  [3:0]  o_ct_out,
  output reg  [3:0]  o_ct_oe,
  input  wire [3:0]  i_strobe_port_function_enable,
  input  wire [3:0]  i_ct_direction,
  input  wire [3:0]  i_ct_port_data,
  output reg  [7:0]  o_dh_out,
  output reg  [7:0]  o_dh_oe,
  input  wire [7:0]  i_upper_address_port_function_enable,
  input  wire [7:0]  i_dh_direction,
  input  wire [7:0]  i_dh_port_data,
  input  wire [15:0] i_dl_in,
  output reg  [15:0] o_dl_out,
  output reg  [15:0] o_dl_oe,
  input  wire [15:0] i_data_port_function_enable,
  input  wire [15:0] i_dl_direction,
  input  wire [15:0] i_dl_port_data
);

  // One-hot bus states
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_T1   = 7'h02;
  localparam [6:0] ST_T2   = 7'h04;
  localparam [6:0] ST_TW   = 7'h08;
  localparam [6:0] ST_T3   = 7'h10;
  localparam [6:0] ST_HOLD = 7'h20;
  localparam [6:0] ST_REL  = 7'h40;
  localparam       NPIN    = 36;

  reg  [6:0]  state_r;
  reg  [6:0]  state_nxt;
  reg  [15:0] div_r;
  reg         clk_r;
  reg         rise_en;
  reg         fall_en;
  reg  [3:0]  cm_s1_r;
  reg  [3:0]  cm_s2_r;
  reg  [15:0] dl_s1_r;
  reg  [15:0] dl_s2_r;
  reg  [15:0] p9_s1_r;
  reg         wait_lat_r;
  reg         ack_r;
  reg         address_latch_strobe_r;
  reg  [23:0] addr_r;
  reg  [15:0] wdata_r;
  reg  [1:0]  be_r;
  reg  [1:0]  blk_r;
  reg         read_r;
  reg         sep_r;

  wire        wait_act = i_bus_control_port_function_enable[`XBPI_CM_WAIT]
                         & ~cm_s2_r[`XBPI_CM_WAIT];
  wire        hreq_act = i_bus_control_port_function_enable[`XBPI_CM_HREQ]
                         & ~cm_s2_r[`XBPI_CM_HREQ];
  wire        in_cyc   = |(state_r & (ST_T1 | ST_T2 | ST_TW | ST_T3));
  wire        in_data  = |(state_r & (ST_T2 | ST_TW | ST_T3));
  wire        float    = state_r[5];

  // Clock pin divider; enables mark its rising and falling edges
  always @(posedge i_clk)
  begin
    rise_en <= 1'h0;
    fall_en <= 1'h0;
    if (i_srst)
    begin
      div_r <= 16'h0000;
      clk_r <= 1'h0;
    end
    else if (div_r == CLK_HALF[15:0] - 16'h0001)
    begin
      div_r   <= 16'h0000;
      clk_r   <= ~clk_r;
      rise_en <= ~clk_r;
      fall_en <= clk_r;
    end
    else
      div_r <= div_r + 16'h0001;
  end

  // Two-flop synchronisers for pins; wait and hold are asynchronous
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cm_s1_r <= 4'hf;
      cm_s2_r <= 4'hf;
      dl_s1_r <= 16'h0000;
      dl_s2_r <= 16'h0000;
      p9_s1_r <= 16'h0000;
      o_p9_pin_sync <= 16'h0000;
    end
    else
    begin
      cm_s1_r <= i_cm_in;
      cm_s2_r <= cm_s1_r;
      dl_s1_r <= i_dl_in;
      dl_s2_r <= dl_s1_r;
      p9_s1_r <= i_p9_in;
      o_p9_pin_sync <= p9_s1_r;
    end
  end

  // Next bus state, decided at each rising edge of the clock pin
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (hreq_act)
          state_nxt = ST_HOLD;
        else if (i_req)
          state_nxt = ST_T1;
      ST_T1:
        if (sep_r && wait_act)
          state_nxt = ST_TW;
        else
          state_nxt = ST_T2;
      ST_T2:
        if (!sep_r && wait_lat_r)
          state_nxt = ST_TW;
        else
          state_nxt = ST_T3;
      ST_TW:
        if (sep_r)
          state_nxt = wait_act ? ST_TW : ST_T2;
        else
          state_nxt = wait_lat_r ? ST_TW : ST_T3;
      ST_T3:
        state_nxt = ST_IDLE;
      ST_HOLD:
        if (ack_r && !hreq_act)
          state_nxt = ST_REL;
      ST_REL:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer; a pending cycle waits in idle until the hold is over
  always @(posedge i_clk)
  begin
    o_done <= 1'h0;
    if (i_srst)
    begin
      state_r    <= ST_IDLE;
      ack_r      <= 1'h0;
      wait_lat_r <= 1'h0;
      address_latch_strobe_r     <= 1'h1;
      addr_r     <= 24'h00_0000;
      wdata_r    <= 16'h0000;
      be_r       <= 2'h0;
      blk_r      <= 2'h0;
      read_r     <= 1'h0;
      sep_r      <= 1'h0;
      o_rdata    <= 16'h0000;
      o_bus_held <= 1'h0;
    end
    else
    begin
      if (rise_en)
      begin
        state_r <= state_nxt;
        if (state_r == ST_IDLE && state_nxt == ST_T1)
        begin
          addr_r  <= i_req_addr;
          wdata_r <= i_req_wdata;
          be_r    <= i_req_be;
          blk_r   <= i_req_block;
          read_r  <= i_req_read;
          sep_r   <= i_sep_mode;
        end
        // Grant follows the float by one clock-pin period
        if (state_r == ST_HOLD)
          ack_r <= hreq_act | ~ack_r;
        o_done <= state_r[4];
      end
      // Muxed mode catches wait at falling edges of T2 and TW
      if (fall_en && (state_r == ST_T2 || state_r == ST_TW))
        wait_lat_r <= wait_act;
      if (fall_en && state_r == ST_T1)
        address_latch_strobe_r <= 1'h0;
      if (fall_en && state_r == ST_T3)
      begin
        address_latch_strobe_r <= 1'h1;
        if (read_r)
          o_rdata <= dl_s2_r;
      end
      o_bus_held <= ack_r;
    end
  end

  // Function values of each pin group except the high address
  reg  [3:0]  cm_fn_out;
  reg  [3:0]  cm_fn_oe;
  reg  [3:0]  cs_fn_out;
  reg  [3:0]  ct_fn_out;
  reg  [15:0] dl_fn_out;
  reg  [15:0] dl_fn_oe;
  integer     k;

  always @*
  begin
    cm_fn_out = 4'h0;
    cm_fn_oe  = 4'h0;
    cm_fn_out[`XBPI_CM_CLK]  = clk_r;
    cm_fn_oe[`XBPI_CM_CLK]   = 1'h1;
    cm_fn_out[`XBPI_CM_HACK] = ~ack_r;
    cm_fn_oe[`XBPI_CM_HACK]  = 1'h1;
    for (k = 0; k < 4; k = k + 1)
      cs_fn_out[k] = ~(in_cyc && blk_r == k[1:0]);
    ct_fn_out[`XBPI_CT_WR0]  = ~(in_data & ~read_r & be_r[0]);
    ct_fn_out[`XBPI_CT_WR1]  = ~(in_data & ~read_r & be_r[1]);
    ct_fn_out[`XBPI_CT_RD]   = ~(in_data & read_r);
    ct_fn_out[`XBPI_CT_ADDRESS_LATCH_STROBE] = address_latch_strobe_r;
    // Muxed lines carry address in T1 and data after it
    if (!sep_r && state_r == ST_T1)
      dl_fn_out = addr_r[15:0];
    else
      dl_fn_out = wdata_r;
    if (float)
      dl_fn_oe = 16'h0000;
    else if (!sep_r && state_r == ST_T1)
      dl_fn_oe = 16'hffff;
    else if (!read_r && (sep_r ? in_cyc : in_data))
      dl_fn_oe = 16'hffff;
    else
      dl_fn_oe = 16'h0000;
  end

  // Port or function choice for every control pin
  wire [NPIN-1:0] fn_en = {i_bus_control_port_function_enable,
                           i_select_port_function_enable,
                           i_strobe_port_function_enable,
                           i_upper_address_port_function_enable,
                           i_data_port_function_enable};
  wire [NPIN-1:0] pdir  = {i_cm_direction, i_cs_direction, i_ct_direction,
                           i_dh_direction, i_dl_direction};
  wire [NPIN-1:0] pdat  = {i_cm_port_data, i_cs_port_data, i_ct_port_data,
                           i_dh_port_data, i_dl_port_data};
  wire [NPIN-1:0] f_out = {cm_fn_out, cs_fn_out, ct_fn_out, addr_r[23:16], dl_fn_out};
  // Selects, strobes and high address float together; bus-control pins keep their own enables
  wire [NPIN-1:0] f_oe  = {cm_fn_oe, {16{~float}}, dl_fn_oe};
  wire [NPIN-1:0] pin_out;
  wire [NPIN-1:0] pin_oe;
  wire [15:0]     p9_out;
  wire [15:0]     p9_oe;
  wire [15:0]     od_en = i_p9_open_drain & `XBPI_P9_OD_MASK;

  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1)
    begin : g_pin
      // Direction bit high means input while in port mode
      assign pin_out[g] = fn_en[g] ? f_out[g] : pdat[g];
      assign pin_oe[g]  = fn_en[g] ? f_oe[g] : ~pdir[g];
    end
    for (g = 0; g < 16; g = g + 1)
    begin : g_p9
      wire po = ~i_port9_function_enable[g] ? i_p9_port_data[g]
              : i_port9_function_select[g] ? i_p9_alt2_out[g] : addr_r[g];
      wire pe = ~i_port9_function_enable[g] ? ~i_port9_direction[g]
              : i_port9_function_select[g] ? i_p9_alt2_oe[g] : ~float;
      // Open drain only pulls low; high is left to the pull-up
      assign p9_out[g] = od_en[g] ? 1'h0 : po;
      assign p9_oe[g]  = od_en[g] ? (pe & ~po) : pe;
    end
  endgenerate

  // All pins leave through flops; reset leaves every pin undriven
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      {o_cm_out, o_cs_out, o_ct_out, o_dh_out, o_dl_out} <= 36'h0_0000_0000;
      {o_cm_oe, o_cs_oe, o_ct_oe, o_dh_oe, o_dl_oe}      <= 36'h0_0000_0000;
      o_p9_out <= 16'h0000;
      o_p9_oe  <= 16'h0000;
    end
    else
    begin
      {o_cm_out, o_cs_out, o_ct_out, o_dh_out, o_dl_out} <= pin_out;
      {o_cm_oe, o_cs_oe, o_ct_oe, o_dh_oe, o_dl_oe}      <= pin_oe;
      o_p9_out <= p9_out;
      o_p9_oe  <= p9_oe;
    end
  end

endmodule
